// file: rtl/pmsc_stall_ctrl.sv
// Stall and timing control for the fixed-point pipeline memory accesses.
// Assumes one clock, synchronous inputs, and memories that report ready.
`timescale 1ns/1ps
`include "pmsc_defs.svh"

module pmsc_stall_ctrl
  import pmsc_pkg::*;
#(
  parameter int ADDR_W = `PMSC_ADDR_W,
  parameter int SPACE_W = `PMSC_SPACE_W,
  parameter int NUM_BANKS = `PMSC_NUM_BANKS,
  parameter int NOP_CNT_W = `PMSC_NOP_CNT_W
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Fetch side
  input wire logic fetch_req_i,
  input wire logic fetch_mem_ready_i,
  // Data port A, first access of a parallel pair
  input wire logic load_a_valid_i,
  input wire logic [ADDR_W-1:0] load_a_addr_i,
  input wire logic [SPACE_W-1:0] load_a_space_i,
  input wire pmsc_size_t load_a_size_i,
  // Data port B, second access of a parallel pair
  input wire logic load_b_valid_i,
  input wire logic [ADDR_W-1:0] load_b_addr_i,
  input wire logic [SPACE_W-1:0] load_b_space_i,
  input wire pmsc_size_t load_b_size_i,
  input wire logic data_mem_ready_i,
  // Issue side
  input wire logic packet_issue_i,
  input wire logic branch_issue_i,
  input wire logic nop_issue_i,
  input wire logic [NOP_CNT_W-1:0] nop_count_i,
  // Pipeline control
  output logic pipe_advance_o,
  output logic mem_stall_o,
  output logic bank_stall_o,
  output logic issue_hold_o,
  output logic branch_target_e1_o,
  // Fetch phase flags
  output logic fetch_address_generate_phase_o,
  output logic fetch_address_send_phase_o,
  output logic fetch_access_wait_phase_o,
  output logic fetch_packet_receive_phase_o,
  output logic dispatch_phase_o,
  // Data phase flags
  output logic execute_phase_one_o,
  output logic data_addr_send_o,
  output logic execute_phase_three_o,
  output logic execute_phase_four_o,
  output logic execute_phase_five_o,
  // Bank strobes
  output logic [NUM_BANKS-1:0] bank_a_sel_o,
  output logic [NUM_BANKS-1:0] bank_b_sel_o,
  output logic bank_a_access_o,
  output logic bank_b_access_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] fetch_ph;
    logic [4:0] load_ph;
    logic b_second;
    logic a_done;
    logic [NUM_BANKS-1:0] sel_a;
    logic [NUM_BANKS-1:0] sel_b;
    logic [SPACE_W-1:0] space_a;
    logic [SPACE_W-1:0] space_b;
    logic b_valid;
    logic [NOP_CNT_W-1:0] nop_left;
    logic [2:0] br_slots;
    logic br_fire;
  } pmsc_state_t;

  pmsc_state_t st;
  pmsc_state_t next_st;

  logic [NUM_BANKS-1:0] dec_a;
  logic [NUM_BANKS-1:0] dec_b;
  logic same_bank;
  logic mem_stall;
  logic bank_stall;
  logic advance;

  // ----------------------------------------------------------------
  // Bank decode
  // ----------------------------------------------------------------
  function automatic logic [NUM_BANKS-1:0] bank_decode(
    input logic [ADDR_W-1:0] addr,
    input pmsc_size_t size
  );
    logic [NUM_BANKS-1:0] one;
    int unsigned idx;
    one = '0;
    idx = int'(addr[`PMSC_BANK_MSB:`PMSC_BANK_LSB]);
    one[idx % NUM_BANKS] = 1'b1;
    if (size == PMSC_SIZE_WORD)
    begin
      one[(idx + 1) % NUM_BANKS] = 1'b1;
    end
    return one;
  endfunction

  assign dec_a = bank_decode(load_a_addr_i, load_a_size_i);
  assign dec_b = bank_decode(load_b_addr_i, load_b_size_i);

  // ----------------------------------------------------------------
  // Stall sources
  // ----------------------------------------------------------------
  // Conflict only inside one memory space, on the access phase
  assign same_bank = st.load_ph[2] && st.b_valid && !st.b_second
                     && (st.space_a == st.space_b)
                     && ((st.sel_a & st.sel_b) != '0);
  assign bank_stall = same_bank;
  // Ready is looked at only in fetch wait and execute phase three
  assign mem_stall = (st.fetch_ph[2] && !fetch_mem_ready_i)
                     || (st.load_ph[2] && !data_mem_ready_i);
  assign advance = !mem_stall && !bank_stall;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.br_fire = 1'b0;
    if (advance)
    begin
      // Fetch sequence: generate, send, wait, receive, dispatch
      next_st.fetch_ph = {st.fetch_ph[3:0], fetch_req_i};
      // Load sequence: execute phases one through five
      next_st.load_ph = {st.load_ph[3:0], load_a_valid_i || load_b_valid_i};
      if (st.load_ph[2])
      begin
        next_st.b_second = 1'b0;
      end
      if (load_a_valid_i || load_b_valid_i)
      begin
        next_st.sel_a = load_a_valid_i ? dec_a : '0;
        next_st.sel_b = dec_b;
        next_st.space_a = load_a_space_i;
        next_st.space_b = load_b_space_i;
        next_st.b_valid = load_a_valid_i && load_b_valid_i;
        if (!load_a_valid_i)
        begin
          next_st.sel_a = dec_b;
          next_st.space_a = load_b_space_i;
        end
      end
      // Branch delay slots count down, target enters phase one after five
      if (st.br_slots != 3'h0)
      begin
        next_st.br_slots = 3'(st.br_slots - 3'h1);
        if (st.br_slots == 3'h1)
        begin
          next_st.br_fire = 1'b1;
          next_st.nop_left = '0;
        end
      end
      else if (st.nop_left != '0)
      begin
        next_st.nop_left = NOP_CNT_W'(st.nop_left - 1'b1);
      end
      if (branch_issue_i)
      begin
        next_st.br_slots = `PMSC_BRANCH_DELAY_SLOTS;
      end
      if (nop_issue_i && nop_count_i > NOP_CNT_W'(1) && !(st.br_slots == 3'h1))
      begin
        next_st.nop_left = NOP_CNT_W'(nop_count_i - 1'b1);
      end
    end
    else if (bank_stall)
    begin
      // First access done now, second takes the extra cycle
      next_st.b_second = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pipe_advance_o = advance;
  assign mem_stall_o = mem_stall;
  assign bank_stall_o = bank_stall;
  assign issue_hold_o = (st.nop_left != '0) && !st.br_fire;
  assign branch_target_e1_o = st.br_fire;
  assign fetch_address_generate_phase_o = st.fetch_ph[0];
  assign fetch_address_send_phase_o = st.fetch_ph[1];
  assign fetch_access_wait_phase_o = st.fetch_ph[2];
  assign fetch_packet_receive_phase_o = st.fetch_ph[3];
  assign dispatch_phase_o = st.fetch_ph[4];
  assign execute_phase_one_o = st.load_ph[0];
  assign data_addr_send_o = st.load_ph[1];
  assign execute_phase_three_o = st.load_ph[2];
  assign execute_phase_four_o = st.load_ph[3];
  assign execute_phase_five_o = st.load_ph[4];
  assign bank_a_sel_o = st.sel_a;
  assign bank_b_sel_o = st.sel_b;
  assign bank_a_access_o = st.load_ph[2] && !st.b_second;
  assign bank_b_access_o = st.load_ph[2] && st.b_valid && (st.b_second || !same_bank);

endmodule

// file: rtl/pmsc_defs.svh
// Constants for the pipeline memory stall control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PMSC_DEFS_SVH
`define PMSC_DEFS_SVH

// ----------------------------------------------------------------
// Pipeline geometry
// ----------------------------------------------------------------
`define PMSC_BRANCH_DELAY_SLOTS 3'h5
`define PMSC_NOP_CNT_W 4
`define PMSC_NUM_BANKS 4
`define PMSC_BANK_LSB 1
`define PMSC_BANK_MSB 2
`define PMSC_ADDR_W 32
`define PMSC_SPACE_W 2

`endif

// file: rtl/pmsc_pkg.sv
// Types for the pipeline memory stall control block.
// Assumes the constants header is on the include path.
`include "pmsc_defs.svh"

package pmsc_pkg;

  // ----------------------------------------------------------------
  // Access sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMSC_SIZE_BYTE,
    PMSC_SIZE_HALF,
    PMSC_SIZE_WORD
  } pmsc_size_t;

  // ----------------------------------------------------------------
  // Phase of a memory access sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMSC_PH_ADDR_GEN,
    PMSC_PH_ADDR_SEND,
    PMSC_PH_MEM_ACCESS,
    PMSC_PH_RECEIVE,
    PMSC_PH_DELIVER
  } pmsc_phase_t;

endpackage

// file: sim/pmsc_mem_model.sv
// Ready model of the program and data memories.
// Assumes phase flags and advance come from the stall block.
`timescale 1ns/1ps
module pmsc_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Access state
  input wire logic slow_i,
  input wire logic adv_i,
  input wire logic fetch_wait_i,
  input wire logic data_e3_i,
  // Ready answers
  output logic fetch_ready_o,
  output logic data_ready_o
);
  logic f_seen;
  logic d_seen;
  // Slow memory refuses the first cycle of every access
  assign fetch_ready_o = !slow_i || f_seen;
  assign data_ready_o = !slow_i || d_seen;
  always_ff @(posedge clk_i)
  begin
    f_seen <= !sys_rst_i && fetch_wait_i && !adv_i;
    d_seen <= !sys_rst_i && data_e3_i && !adv_i;
  end
endmodule

// file: sim/pmsc_stall_ctrl_chk.sv
// Port assertions for the pipeline stall control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pmsc_stall_ctrl_chk (
  // Clock, reset and inputs
  input wire logic clk_i, sys_rst_i, data_mem_ready_i, branch_issue_i, nop_issue_i,
  input wire logic [3:0] nop_count_i,
  // Watched outputs
  input wire logic pipe_advance_o, mem_stall_o, bank_stall_o, issue_hold_o, branch_target_e1_o,
  input wire logic fetch_access_wait_phase_o, fetch_packet_receive_phase_o, data_addr_send_o,
  input wire logic execute_phase_three_o, execute_phase_four_o, bank_b_access_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_dw; execute_phase_three_o && !data_mem_ready_i |-> mem_stall_o; endproperty
  a_dw: assert property (p_dw) else $error("no stall on busy data");
  property p_frz; !pipe_advance_o |=> $stable({fetch_access_wait_phase_o, execute_phase_three_o}); endproperty
  a_frz: assert property (p_frz) else $error("phase moved in stall");
  property p_fsq; fetch_access_wait_phase_o && pipe_advance_o |=> fetch_packet_receive_phase_o; endproperty
  a_fsq: assert property (p_fsq) else $error("fetch receive late");
  property p_dsq; data_addr_send_o && pipe_advance_o |=> execute_phase_three_o; endproperty
  a_dsq: assert property (p_dsq) else $error("load access late");
  property p_bk; bank_stall_o |=> !bank_stall_o && bank_b_access_o; endproperty
  a_bk: assert property (p_bk) else $error("bank stall not one cycle");
  property p_jn; bank_stall_o ##1 pipe_advance_o |=> execute_phase_four_o; endproperty
  a_jn: assert property (p_jn) else $error("pair not joined");
  property p_br; branch_issue_i && pipe_advance_o ##1 pipe_advance_o[*5] |=> branch_target_e1_o && !issue_hold_o;
  endproperty
  a_br: assert property (p_br) else $error("branch target late");
  property p_nop; (!branch_issue_i)[*6] ##0 (nop_issue_i && nop_count_i == 4'h5) |=> issue_hold_o[*4]; endproperty
  a_nop: assert property (p_nop) else $error("idle hold short");
  c_bk: cover property (bank_stall_o);
  c_ms: cover property (mem_stall_o);
  c_br: cover property (branch_target_e1_o);
endmodule
bind pmsc_stall_ctrl pmsc_stall_ctrl_chk u_chk (.*);

// file: sim/pmsc_stall_ctrl_tb.sv
// Self-checking bench for the pipeline stall control block.
// Assumes the memory model and the checker are compiled first.
`timescale 1ns/1ps
module pmsc_stall_ctrl_tb
  import pmsc_pkg::*;
;
  logic clk_i = '0, sys_rst_i = '1, fetch_req_i = '0, load_a_valid_i = '0, load_b_valid_i = '0, slow = '0;
  logic packet_issue_i = '0, branch_issue_i = '0, nop_issue_i = '0;
  logic [31:0] load_a_addr_i = '0, load_b_addr_i = '0;
  logic [1:0] load_a_space_i = '0, load_b_space_i = '0;
  logic [3:0] nop_count_i = '0;
  pmsc_size_t load_a_size_i = PMSC_SIZE_BYTE, load_b_size_i = PMSC_SIZE_BYTE;
  wire logic fetch_mem_ready_i, data_mem_ready_i;
  logic pipe_advance_o, mem_stall_o, bank_stall_o, issue_hold_o, branch_target_e1_o, bank_a_access_o;
  logic fetch_address_generate_phase_o, fetch_address_send_phase_o, fetch_access_wait_phase_o;
  logic fetch_packet_receive_phase_o, dispatch_phase_o, execute_phase_one_o, data_addr_send_o;
  logic execute_phase_three_o, execute_phase_four_o, execute_phase_five_o, bank_b_access_o;
  logic [3:0] bank_a_sel_o, bank_b_sel_o;
  int errors = 0, checks = 0;
  pmsc_stall_ctrl dut (.*);
  pmsc_mem_model u_mem (.clk_i, .sys_rst_i, .slow_i(slow), .adv_i(pipe_advance_o),
    .fetch_wait_i(fetch_access_wait_phase_o), .data_e3_i(execute_phase_three_o),
    .fetch_ready_o(fetch_mem_ready_i), .data_ready_o(data_mem_ready_i));
  initial forever #5 clk_i = ~clk_i;
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task step;
    @(posedge clk_i);
    #1;
  endtask
  task t_fetch(input logic s);
    slow = s;
    fetch_req_i = '1;
    step;
    fetch_req_i = '0;
    for (int k = 0; k < 5 + s; k++)
    begin
      chk({fetch_address_generate_phase_o, fetch_address_send_phase_o, fetch_access_wait_phase_o,
        fetch_packet_receive_phase_o, dispatch_phase_o}, 5'h10 >> (k - (s && k > 2)));
      chk(mem_stall_o, s && k == 2);
      step;
    end
  endtask
  task t_load(input logic [31:0] a, b, input pmsc_size_t za, zb, input logic [1:0] sp,
    input logic s, hit, input logic [3:0] ma);
    int n;
    slow = s;
    load_a_addr_i = a;
    load_b_addr_i = b;
    load_a_size_i = za;
    load_b_size_i = zb;
    load_b_space_i = sp;
    {load_a_valid_i, load_b_valid_i} = 2'h3;
    step;
    {load_a_valid_i, load_b_valid_i} = 2'h0;
    chk(execute_phase_one_o, 1);
    step;
    chk(data_addr_send_o, 1);
    step;
    chk({execute_phase_three_o, bank_stall_o, mem_stall_o}, {1'h1, hit, s});
    chk(bank_a_sel_o, ma);
    for (n = 1; n < 5; n++)
    begin
      step;
      if (n == 1 && hit)
        chk(bank_b_access_o, 1);
      if (execute_phase_four_o)
        break;
    end
    chk(n, 1 + hit + s);
    if (n == 5)
      end_sim;
  endtask
  task t_flow(input logic b);
    branch_issue_i = b;
    nop_count_i = 4'h5;
    for (int k = 0; k < 11; k++)
    begin
      nop_issue_i = k == 5;
      chk({branch_target_e1_o, issue_hold_o}, {b && k == 6, !b && k > 5 && k < 10});
      step;
      branch_issue_i = '0;
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    sys_rst_i = '0;
    t_fetch(0);
    t_fetch(1);
    t_load(0, 0, PMSC_SIZE_WORD, PMSC_SIZE_WORD, 0, 0, 1, 4'h3);
    t_load(0, 4, PMSC_SIZE_WORD, PMSC_SIZE_WORD, 0, 0, 0, 4'h3);
    t_load(0, 2, PMSC_SIZE_HALF, PMSC_SIZE_WORD, 0, 0, 0, 4'h1);
    t_load(0, 0, PMSC_SIZE_BYTE, PMSC_SIZE_WORD, 0, 0, 1, 4'h1);
    t_load(6, 0, PMSC_SIZE_WORD, PMSC_SIZE_BYTE, 0, 0, 1, 4'h9);
    t_load(0, 0, PMSC_SIZE_WORD, PMSC_SIZE_WORD, 1, 0, 0, 4'h3);
    t_load(0, 4, PMSC_SIZE_WORD, PMSC_SIZE_WORD, 0, 1, 0, 4'h3);
    t_flow(0);
    t_flow(1);
    end_sim;
  end
endmodule
